// *** verilog/jfp_prog_port.v ***
// Purpose: Scan-port programming front end behind a four-pin test port
// Assumes: clk_i at 20 MHz oversamples TCK; TCK at least 8x slower
// Notes: TAP actions run on the sampled TCK edge, so they lag the pin
`timescale 1ns/1ps
`include "jfp_consts.vh"

module jfp_prog_port (
   input wire clk_i, // Chip clock, 20 MHz
   input wire rst_i, // Power-on reset, async, active high
   input wire tck_i, // Test clock pin
   input wire tms_i, // Test mode select pin
   input wire tdi_i, // Test data in pin
   output reg tdo_o, // Test data out
   output reg tdo_oe_o, // TDO driven while high
   input wire scan_port_enable_fuse_i, // Enable fuse programmed
   input wire ext_reset_n_i, // External reset pin, active low
   input wire core_dis_wr_i, // Core writes the disable bit
   input wire core_dis_data_i, // Value written by the core
   output reg scan_port_disable_bit_o, // Disable bit of the core control register
   input wire [1:0] clk_opt_fuse_i, // Clock option fuses, time-out select
   output reg core_reset_o, // Core held in reset
   output reg prog_mode_o, // Programming mode active
   input wire [14:0] cmd_result_i, // Result of previous command
   output reg [14:0] cmd_o, // Command on the flash control inputs
   output reg cmd_exec_o, // One-cycle execute clock
   input wire addr_load_i, // Flash controller presets address
   input wire [15:0] addr_preset_i, // Preset word address
   output reg [15:0] word_addr_o, // Word address counter
   input wire [15:0] rd_word_i, // Flash word at word_addr_o
   output reg page_wr_valid_o, // Page buffer write pending
   input wire page_wr_ready_i, // Page buffer accepts the write
   output reg [15:0] page_wr_addr_o, // Word address of the write
   output reg page_wr_high_o, // High byte when set
   output reg [7:0] page_wr_data_o // Byte to write
);

   // ==================================================================
   // TAP states
   localparam S_TLR = 16'h0001;
   localparam S_RTI = 16'h0002;
   localparam S_SDR = 16'h0004;
   localparam S_CDR = 16'h0008;
   localparam S_SHDR = 16'h0010;
   localparam S_E1DR = 16'h0020;
   localparam S_PDR = 16'h0040;
   localparam S_E2DR = 16'h0080;
   localparam S_UDR = 16'h0100;
   localparam S_SIR = 16'h0200;
   localparam S_CIR = 16'h0400;
   localparam S_SHIR = 16'h0800;
   localparam S_E1IR = 16'h1000;
   localparam S_PIR = 16'h2000;
   localparam S_E2IR = 16'h4000;
   localparam S_UIR = 16'h8000;

   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire ext_rst_n_s;
   reg tck_d;
   wire tck_rise;
   wire tck_fall;
   wire port_usable;
   reg [15:0] state;
   reg [15:0] next_state;
   reg [3:0] ir;
   reg [3:0] ir_shift;
   reg rst_hold;
   reg bypass;
   reg [15:0] key_shift;
   reg [14:0] cmd_shift;
   reg byte_hi;
   reg first_load;
   reg pl_pending;
   reg [7:0] pl_byte;
   reg pl_high;
   reg [15:0] pl_addr;
   reg [1:0] dis_cnt;
   reg [12:0] to_cnt;
   reg [12:0] to_sel;
   reg tdo_next;
   wire upd_dr;
   wire cap_dr;
   wire sh_dr;
   wire pload_upd;
   wire pread_cap;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_pop;
   wire [24:0] fifo_out;

   // ==================================================================
   // Pin synchronisers
   jfp_sync u_sync_tck (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rst_val_i(1'b0),
      .d_i(tck_i),
      .q_o(tck_s)
   );
   jfp_sync u_sync_tms (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rst_val_i(1'b0),
      .d_i(tms_i),
      .q_o(tms_s)
   );
   jfp_sync u_sync_tdi (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rst_val_i(1'b0),
      .d_i(tdi_i),
      .q_o(tdi_s)
   );
   jfp_sync u_sync_rst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rst_val_i(1'b0),
      .d_i(ext_reset_n_i),
      .q_o(ext_rst_n_s)
   );

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;
   assign port_usable = scan_port_enable_fuse_i & ~scan_port_disable_bit_o;

   // ==================================================================
   // Port disable bit
   // Hardware clear wins over a core write: the core is in reset then
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dis_cnt <= 2'd0;
         scan_port_disable_bit_o <= 1'b0;
      end else begin
         if (ext_rst_n_s) begin
            dis_cnt <= 2'd0;
         end else if (dis_cnt != `JFP_DISABLE_CLR_CYC) begin
            dis_cnt <= dis_cnt + 2'd1;
         end
         if (!ext_rst_n_s && (dis_cnt == `JFP_DISABLE_CLR_CYC - 2'd1)) begin
            scan_port_disable_bit_o <= 1'b0;
         end else if (core_dis_wr_i) begin
            scan_port_disable_bit_o <= core_dis_data_i;
         end
      end
   end

   // ==================================================================
   // TAP controller
   always @* begin
      next_state = S_TLR;
      case (state)
         S_TLR: next_state = tms_s ? S_TLR : S_RTI;
         S_RTI: next_state = tms_s ? S_SDR : S_RTI;
         S_SDR: next_state = tms_s ? S_SIR : S_CDR;
         S_CDR: next_state = tms_s ? S_E1DR : S_SHDR;
         S_SHDR: next_state = tms_s ? S_E1DR : S_SHDR;
         S_E1DR: next_state = tms_s ? S_UDR : S_PDR;
         S_PDR: next_state = tms_s ? S_E2DR : S_PDR;
         S_E2DR: next_state = tms_s ? S_UDR : S_SHDR;
         S_UDR: next_state = tms_s ? S_SDR : S_RTI;
         S_SIR: next_state = tms_s ? S_TLR : S_CIR;
         S_CIR: next_state = tms_s ? S_E1IR : S_SHIR;
         S_SHIR: next_state = tms_s ? S_E1IR : S_SHIR;
         S_E1IR: next_state = tms_s ? S_UIR : S_PIR;
         S_PIR: next_state = tms_s ? S_E2IR : S_PIR;
         S_E2IR: next_state = tms_s ? S_UIR : S_SHIR;
         S_UIR: next_state = tms_s ? S_SDR : S_RTI;
         default: next_state = S_TLR;
      endcase
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= S_TLR;
         ir <= `JFP_IR_BYPASS;
         ir_shift <= `JFP_IR_CAPTURE;
      end else if (!port_usable) begin
         state <= S_TLR;
         ir <= `JFP_IR_BYPASS;
      end else if (tck_rise) begin
         state <= next_state;
         if (state == S_TLR) begin
            ir <= `JFP_IR_BYPASS;
         end
         if (state == S_CIR) begin
            ir_shift <= `JFP_IR_CAPTURE;
         end
         if (state == S_SHIR) begin
            ir_shift <= {tdi_s, ir_shift[3:1]};
         end
         if (state == S_UIR) begin
            ir <= ir_shift;
         end
      end
   end

   assign cap_dr = port_usable & tck_rise & (state == S_CDR);
   assign sh_dr = port_usable & tck_rise & (state == S_SHDR);
   assign upd_dr = port_usable & tck_rise & (state == S_UDR);
   assign pload_upd = upd_dr & (ir == `JFP_IR_PLOAD) & prog_mode_o;
   assign pread_cap = cap_dr & (ir == `JFP_IR_PREAD) & prog_mode_o;

   // ==================================================================
   // Reset, unlock and bypass registers
   // Reset register is never cleared by the TAP itself
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_hold <= 1'b0;
         bypass <= 1'b0;
         key_shift <= `JFP_KEY_RESET;
         prog_mode_o <= 1'b0;
      end else begin
         if (sh_dr && (ir == `JFP_IR_RESET_HOLD)) begin
            rst_hold <= tdi_s;
         end
         if (cap_dr) begin
            bypass <= 1'b0;
         end else if (sh_dr) begin
            bypass <= tdi_s;
         end
         if (sh_dr && (ir == `JFP_IR_UNLOCK)) begin
            key_shift <= {tdi_s, key_shift[15:1]};
         end
         if (upd_dr && (ir == `JFP_IR_UNLOCK)) begin
            prog_mode_o <= (key_shift == `JFP_UNLOCK_SIG);
         end
      end
   end

   // ==================================================================
   // Core reset with fuse-selected time-out
   always @* begin
      case (clk_opt_fuse_i)
         2'd0: to_sel = `JFP_TIMEOUT_0;
         2'd1: to_sel = `JFP_TIMEOUT_1;
         2'd2: to_sel = `JFP_TIMEOUT_2;
         default: to_sel = `JFP_TIMEOUT_3;
      endcase
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         to_cnt <= 13'h0000;
         core_reset_o <= 1'b0;
      end else if (rst_hold) begin
         to_cnt <= to_sel;
         core_reset_o <= 1'b1;
      end else if (to_cnt != 13'h0000) begin
         to_cnt <= to_cnt - 13'h0001;
         core_reset_o <= 1'b1;
      end else begin
         core_reset_o <= 1'b0;
      end
   end

   // ==================================================================
   // Command and byte register, execute clock
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_shift <= `JFP_CMD_RESET;
         cmd_o <= `JFP_CMD_RESET;
         cmd_exec_o <= 1'b0;
      end else begin
         cmd_exec_o <= port_usable & tck_rise & (state == S_RTI) & prog_mode_o &
            (ir == `JFP_IR_CMD);
         if (cap_dr && (ir == `JFP_IR_CMD)) begin
            cmd_shift <= cmd_result_i;
         end else if (sh_dr && (ir == `JFP_IR_CMD)) begin
            cmd_shift <= {tdi_s, cmd_shift[14:1]};
         end else if (pread_cap) begin
            cmd_shift[7:0] <= byte_hi ? rd_word_i[15:8] : rd_word_i[7:0];
         end else if (sh_dr && ((ir == `JFP_IR_PLOAD) || (ir == `JFP_IR_PREAD))) begin
            cmd_shift[7:0] <= {tdi_s, cmd_shift[7:1]};
         end
         if (upd_dr && (ir == `JFP_IR_CMD) && prog_mode_o) begin
            cmd_o <= cmd_shift;
         end
      end
   end

   // ==================================================================
   // Byte alternation and word address counter
   // A second page-load update while one is still pending is dropped
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         byte_hi <= 1'b0;
         first_load <= 1'b1;
         word_addr_o <= `JFP_ADDR_RESET;
         pl_pending <= 1'b0;
         pl_byte <= 8'h00;
         pl_high <= 1'b0;
         pl_addr <= `JFP_ADDR_RESET;
      end else begin
         if (pl_pending && fifo_in_ready) begin
            pl_pending <= 1'b0;
         end
         if (port_usable && tck_rise && (state == S_UIR)) begin
            byte_hi <= 1'b0;
            first_load <= 1'b1;
         end else if (pload_upd && !pl_pending) begin
            byte_hi <= ~byte_hi;
            first_load <= 1'b0;
            pl_pending <= 1'b1;
            pl_byte <= cmd_shift[7:0];
            pl_high <= byte_hi;
            if (!byte_hi && !first_load) begin
               pl_addr <= word_addr_o + 16'h0001;
            end else begin
               pl_addr <= word_addr_o;
            end
         end else if (pread_cap) begin
            byte_hi <= ~byte_hi;
         end
         if (addr_load_i) begin
            word_addr_o <= addr_preset_i;
         end else if (pload_upd && !pl_pending && !byte_hi && !first_load) begin
            word_addr_o <= word_addr_o + 16'h0001;
         end else if (pread_cap && byte_hi) begin
            word_addr_o <= word_addr_o + 16'h0001;
         end
      end
   end

   // ==================================================================
   // Page buffer write path
   jfp_fifo #(
      .W(`JFP_FIFO_W),
      .D(`JFP_FIFO_DEPTH),
      .AW(`JFP_FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(pl_pending),
      .in_ready_i_n_o(),
      .in_ready_o(fifo_in_ready),
      .in_data_i({pl_addr, pl_high, pl_byte}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out)
   );

   assign fifo_pop = fifo_out_valid & (~page_wr_valid_o | page_wr_ready_i);

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         page_wr_valid_o <= 1'b0;
         page_wr_addr_o <= `JFP_ADDR_RESET;
         page_wr_high_o <= 1'b0;
         page_wr_data_o <= 8'h00;
      end else if (fifo_pop) begin
         page_wr_valid_o <= 1'b1;
         page_wr_addr_o <= fifo_out[24:9];
         page_wr_high_o <= fifo_out[8];
         page_wr_data_o <= fifo_out[7:0];
      end else if (page_wr_ready_i) begin
         page_wr_valid_o <= 1'b0;
      end
   end

   // ==================================================================
   // TDO, changed on falling TCK
   always @* begin
      tdo_next = bypass;
      if (state == S_SHIR) begin
         tdo_next = ir_shift[0];
      end else begin
         case (ir)
            `JFP_IR_RESET_HOLD: tdo_next = rst_hold;
            `JFP_IR_UNLOCK: tdo_next = key_shift[0];
            `JFP_IR_CMD: tdo_next = cmd_shift[0];
            `JFP_IR_PLOAD: tdo_next = cmd_shift[0];
            `JFP_IR_PREAD: tdo_next = cmd_shift[0];
            default: tdo_next = bypass;
         endcase
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (!port_usable) begin
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_o <= tdo_next;
         tdo_oe_o <= (state == S_SHDR) | (state == S_SHIR);
      end
   end

endmodule

// *** verilog/jfp_consts.vh ***
// Purpose: Shared constants of the scan programming port
// Assumes: Included by bare name from every design file that needs it
// Notes: Timing counts are in cycles of clk_i unless the name says NS or TCK
`ifndef JFP_CONSTS_VH
`define JFP_CONSTS_VH

// ====================================================================
// Instruction codes
`define JFP_IR_W 4
`define JFP_IR_RESET_HOLD 4'hc
`define JFP_IR_UNLOCK 4'h4
`define JFP_IR_CMD 4'h5
`define JFP_IR_PLOAD 4'h6
`define JFP_IR_PREAD 4'h7
`define JFP_IR_BYPASS 4'hf
`define JFP_IR_CAPTURE 4'h1

// ====================================================================
// Data register layout
`define JFP_KEY_W 16
`define JFP_KEY_RESET 16'h0000
`define JFP_UNLOCK_SIG 16'ha370
`define JFP_CMD_W 15
`define JFP_CMD_RESET 15'h0000
`define JFP_BYTE_W 8
`define JFP_ADDR_W 16
`define JFP_ADDR_RESET 16'h0000

// ====================================================================
// Timing
`define JFP_CLK_NS 50
`define JFP_TCK_NS 400
`define JFP_PAGE_WR_TCK 11
`define JFP_PAGE_WR_MAX_CYC ((`JFP_PAGE_WR_TCK * `JFP_TCK_NS) / `JFP_CLK_NS)
`define JFP_DISABLE_CLR_CYC 2'd2
`define JFP_TO_W 13
`define JFP_TIMEOUT_0 13'h0010
`define JFP_TIMEOUT_1 13'h0040
`define JFP_TIMEOUT_2 13'h0200
`define JFP_TIMEOUT_3 13'h1000

// ====================================================================
// Page buffer FIFO
`define JFP_FIFO_DEPTH 16
`define JFP_FIFO_AW 4
`define JFP_FIFO_W 25

`endif

// *** verilog/jfp_sync.v ***
// Purpose: Two-stage synchroniser for one level from outside clk_i
// Assumes: Input changes slowly compared with clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps

module jfp_sync (
   input wire clk_i, // Sampling clock
   input wire rst_i, // Asynchronous reset, active high
   input wire rst_val_i, // Unused marker, tie low
   input wire d_i, // Asynchronous level in
   output reg q_o // Synchronised level out
);

   reg meta;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule

// *** verilog/jfp_fifo.v ***
// Purpose: Flop-based FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes: Full and empty derive from an occupancy count
`timescale 1ns/1ps

module jfp_fifo #(
   parameter W = 25,
   parameter D = 16,
   parameter AW = 4
) (
   input wire clk_i, // Clock
   input wire rst_i, // Asynchronous reset, active high
   input wire in_valid_i, // Write request
   output wire in_ready_i_n_o, // Unused, always low
   output wire in_ready_o, // Space available
   input wire [W-1:0] in_data_i, // Write data
   output wire out_valid_o, // Data available
   input wire out_ready_i, // Reader takes head
   output wire [W-1:0] out_data_o // Head entry
);

   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   genvar gi;

   assign in_ready_o = (count != D[AW:0]);
   assign in_ready_i_n_o = 1'b0;
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // ==================================================================
   // Storage, one flop row per entry
   generate
      for (gi = 0; gi < D; gi = gi + 1) begin : g_ent
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               mem[gi] <= {W{1'b0}};
            end else if (push && ({{(32-AW){1'b0}}, wr_ptr} == gi)) begin
               mem[gi] <= in_data_i;
            end
         end
      end
   endgenerate

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

// *** tb/jfp_prog_port_chk.sv ***
// Purpose: Port-level assertions for the scan programming port
// Assumes: Bound to every jfp_prog_port instance
// Notes: Latency bounds cover the two-stage pin synchronisers
`timescale 1ns/1ps
// ====================================================================
// Checker
module jfp_prog_port_chk (
   input wire clk_i, // Clock
   input wire rst_i, // Reset
   input wire tdo_oe_o, // TDO enable
   input wire scan_port_enable_fuse_i, // Fuse
   input wire ext_reset_n_i, // Ext reset
   input wire scan_port_disable_bit_o, // Disable bit
   input wire core_reset_o, // Core reset
   input wire prog_mode_o, // Prog mode
   input wire [14:0] cmd_o, // Command
   input wire cmd_exec_o, // Execute
   input wire addr_load_i, // Preset strobe
   input wire [15:0] addr_preset_i, // Preset
   input wire [15:0] word_addr_o, // Address
   input wire page_wr_valid_o, // Write valid
   input wire page_wr_ready_i, // Write ready
   input wire [15:0] page_wr_addr_o, // Write address
   input wire page_wr_high_o, // High byte
   input wire [7:0] page_wr_data_o // Write byte
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_fuse_off; !scan_port_enable_fuse_i [*3] |-> !tdo_oe_o; endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("TDO on, fuse off");
   property p_dis_off; scan_port_disable_bit_o [*3] |-> !tdo_oe_o; endproperty
   a_dis_off: assert property (p_dis_off) else $error("TDO on, port off");
   property p_dis_clr; scan_port_disable_bit_o && !ext_reset_n_i
      |-> ##[0:6] !scan_port_disable_bit_o; endproperty
   a_dis_clr: assert property (p_dis_clr) else $error("Disable not cleared");
   property p_rst_min; $rose(core_reset_o) |=> core_reset_o [*8]; endproperty
   a_rst_min: assert property (p_rst_min) else $error("Core reset too short");
   property p_exec; cmd_exec_o |-> prog_mode_o ##1 !cmd_exec_o; endproperty
   a_exec: assert property (p_exec) else $error("Bad execute pulse");
   property p_cmd_hold; !$stable(cmd_o) |-> $past(prog_mode_o); endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("Command moved");
   property p_pw_hold; page_wr_valid_o && !page_wr_ready_i |=> page_wr_valid_o
      && $stable({page_wr_addr_o, page_wr_high_o, page_wr_data_o}); endproperty
   a_pw_hold: assert property (p_pw_hold) else $error("Write dropped");
   property p_preset; addr_load_i |=> word_addr_o == $past(addr_preset_i); endproperty
   a_preset: assert property (p_preset) else $error("Preset lost");
   property p_step; !$stable(word_addr_o) && !$past(addr_load_i)
      |-> word_addr_o == $past(word_addr_o) + 16'h1; endproperty
   a_step: assert property (p_step) else $error("Address jump");
endmodule
bind jfp_prog_port jfp_prog_port_chk u_jfp_prog_port_chk (.clk_i, .rst_i, .tdo_oe_o,
   .scan_port_enable_fuse_i, .ext_reset_n_i, .scan_port_disable_bit_o, .core_reset_o,
   .prog_mode_o, .cmd_o, .cmd_exec_o, .addr_load_i, .addr_preset_i, .word_addr_o,
   .page_wr_valid_o, .page_wr_ready_i, .page_wr_addr_o, .page_wr_high_o, .page_wr_data_o);

// *** tb/jfp_jtag_host.sv ***
// Purpose: Test-port programmer driving TCK, TMS and TDI
// Assumes: TCK period 400 ns, held low between frames
// Notes: TDO sampled just before each rising TCK
`timescale 1ns/1ps
// ====================================================================
// Programmer model
module jfp_jtag_host (
   output logic tck_o, // Test clock
   output logic tms_o, // Mode select
   output logic tdi_o, // Data to device
   input wire tdo_i // Data from device
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   task tick(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #200 q = tdo_i;
      tck_o = 1'b1;
      #200 tck_o = 1'b0;
   endtask
   task tap_reset;
      logic q;
      repeat (5) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
   task idle(input int k);
      logic q;
      repeat (k) tick(1'b0, 1'b0, q);
   endtask
   // From Run-Test/Idle back to Run-Test/Idle
   task scan(input logic ir, input logic [15:0] v, input int n, output logic [15:0] o);
      logic q;
      o = 16'h0;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, v[i], q);
         o[i] = q;
      end
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
endmodule

// *** tb/test_jfp_prog_port.sv ***
// Purpose: Self-checking bench for the scan programming port
// Assumes: Host model owns the test pins; bench owns the rest
// Notes: Released TDO shows the inverse of its last value, never a held one
`timescale 1ns/1ps
`include "jfp_consts.vh"
module test_jfp_prog_port;
   logic clk_i = 0, rst_i = 1, fuse = 1, ern = 1, dwr = 0, dd = 0, al = 0, rdy = 1, oe_seen = 0;
   logic [1:0] opt = 2'h3;
   logic [14:0] res = 15'h2a5b;
   logic [15:0] pre = 16'h0, o;
   logic tck, tms, tdi, tdo, oe, dis, crst, prog, exec, pwv, pwh;
   logic [14:0] cmd;
   logic [15:0] wa, pwa;
   logic [7:0] pwd;
   int n_errors = 0, tests_run = 0, n_exec = 0;
   logic [24:0] wq[$];
   wire tdo_w = oe ? tdo : ~tdo;
   wire [15:0] rdw = {wa[7:0] ^ 8'h5a, wa[7:0]};
   always #25 clk_i = ~clk_i;
   jfp_prog_port u_jfp_prog_port (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe), .scan_port_enable_fuse_i(fuse),
      .ext_reset_n_i(ern), .core_dis_wr_i(dwr), .core_dis_data_i(dd),
      .scan_port_disable_bit_o(dis), .clk_opt_fuse_i(opt), .core_reset_o(crst),
      .prog_mode_o(prog), .cmd_result_i(res), .cmd_o(cmd), .cmd_exec_o(exec),
      .addr_load_i(al), .addr_preset_i(pre), .word_addr_o(wa), .rd_word_i(rdw),
      .page_wr_valid_o(pwv), .page_wr_ready_i(rdy), .page_wr_addr_o(pwa),
      .page_wr_high_o(pwh), .page_wr_data_o(pwd));
   jfp_jtag_host u_jfp_jtag_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));
   always @(posedge clk_i) begin
      if (oe) oe_seen <= 1'b1;
      if (exec) n_exec <= n_exec + 1;
      if (pwv && rdy) wq.push_back({pwa, pwh, pwd});
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask
   task step(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task sc(input logic ir, input logic [15:0] v, input int n);
      u_jfp_jtag_host.scan(ir, v, n, o);
      step(1);
   endtask
   task ld(input logic [15:0] a);
      pre = a;
      al = 1'b1;
      step(1);
      al = 1'b0;
   endtask
   task test_done;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ====================================================================
   // Scenarios
   task t_disable;
      fuse = 1'b0;
      sc(1'b1, 16'h4, 4);
      chk(oe_seen, 0);
      fuse = 1'b1;
      dwr = 1'b1;
      dd = 1'b1;
      step(1);
      dwr = 1'b0;
      sc(1'b1, 16'h4, 4);
      chk({dis, oe_seen}, 2'h2);
      ern = 1'b0;
      step(8);
      chk(dis, 0);
      ern = 1'b1;
      step(1);
      u_jfp_jtag_host.tap_reset;
   endtask
   task t_rst;
      sc(1'b1, 16'hc, 4);
      chk(o[3:0], 4'h1);
      sc(1'b0, 16'h1, 1);
      chk(crst, 1);
      sc(1'b0, 16'h0, 1);
      // Release fell about 18 clocks before; time-out is 4096
      step(3900);
      chk(crst, 1);
      step(300);
      chk(crst, 0);
      opt = 2'h1;
      sc(1'b0, 16'h1, 1);
      sc(1'b0, 16'h0, 1);
      chk(crst, 1);
      step(60);
      chk(crst, 0);
      sc(1'b0, 16'h1, 1);
   endtask
   task t_unlock;
      sc(1'b1, 16'h4, 4);
      sc(1'b0, 16'ha371, 16);
      chk(prog, 0);
      sc(1'b0, `JFP_UNLOCK_SIG, 16);
      chk(prog, 1);
   endtask
   task t_cmd;
      int e0;
      sc(1'b1, 16'h5, 4);
      sc(1'b0, 16'h1234, 15);
      chk(o[14:0], res);
      chk(cmd, 15'h1234);
      e0 = n_exec;
      u_jfp_jtag_host.idle(3);
      step(5);
      chk(n_exec - e0, 3);
   endtask
   task t_pload;
      ld(16'h0040);
      sc(1'b1, 16'h6, 4);
      sc(1'b0, 16'h11, 8);
      // Write must reach the page buffer well inside 11 TCK
      step(80);
      chk(wq.size(), 1);
      sc(1'b0, 16'h22, 8);
      rdy = 1'b0;
      sc(1'b0, 16'h33, 8);
      rdy = 1'b1;
      step(20);
      chk(wq[0], {16'h0040, 1'b0, 8'h11});
      chk(wq[1], {16'h0040, 1'b1, 8'h22});
      chk(wq[2], {16'h0041, 1'b0, 8'h33});
   endtask
   task t_pread;
      ld(16'h0010);
      sc(1'b1, 16'h7, 4);
      sc(1'b0, 16'h0, 8);
      chk(o[7:0], 8'h10);
      sc(1'b0, 16'h0, 8);
      chk(o[7:0], 8'h4a);
      sc(1'b0, 16'h0, 8);
      chk({wa, o[7:0]}, {16'h0011, 8'h11});
   endtask
   task t_leave;
      sc(1'b1, 16'h4, 4);
      sc(1'b0, 16'h0, 16);
      chk(prog, 0);
      sc(1'b1, 16'hf, 4);
      sc(1'b0, 16'h1, 2);
      chk(o[1:0], 2'h2);
   endtask
   initial begin
      step(2);
      rst_i = 1'b0;
      step(4);
      chk({dis, prog, wa}, 18'h0);
      t_disable;
      t_rst;
      t_unlock;
      t_cmd;
      t_pload;
      t_pread;
      t_leave;
      test_done;
   end
   initial begin
      #3ms;
      n_errors++;
      test_done;
   end
endmodule
